// ==== design/eipl_top.sv ====
// module: external interrupt pin latch with register port
//
// Strobed register access and the register addresses are this design's own decisions.
`timescale 1ns/1ps

module eipl_top (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic irq_pin_n,
  input wire logic vector_fetch,
  input wire logic break_active,
  input wire logic port_a_line_two_in,
  output logic irq_request,
  output logic wake_request,
  output logic pin_level,
  output logic pin_function_enable,
  output logic pullup_enable
);

  // ---------------------------------------------------------------
  // register port
  // ---------------------------------------------------------------
  eipl_pkg::eipl_bus_type bus;
  assign bus.addr = reg_addr;
  assign bus.wdata = reg_wdata;
  assign bus.wr = reg_wr;
  assign bus.rd = reg_rd;

  logic sel_status;
  logic sel_config;
  logic sel_break;
  logic sel_port;
  assign sel_status = (bus.addr == eipl_pkg::STATUS_CONTROL_OFS);
  assign sel_config = (bus.addr == eipl_pkg::CONFIG_TWO_OFS);
  assign sel_break = (bus.addr == eipl_pkg::BREAK_FLAG_OFS);
  assign sel_port = (bus.addr == eipl_pkg::PORT_A_DATA_OFS);

  logic mask_r;
  logic sense_r;
  logic pin_en_r;
  logic pullup_dis_r;
  logic permit_r;
  logic latch_r;

  // ---------------------------------------------------------------
  // pin synchroniser and edge detect
  // ---------------------------------------------------------------
  logic sync1_r;
  logic sync2_r;
  logic prev_r;
  logic port_s1_r;
  logic port_s2_r;
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      sync1_r <= 1'b1;
      sync2_r <= 1'b1;
      prev_r <= 1'b1;
      port_s1_r <= 1'b0;
      port_s2_r <= 1'b0;
    end else begin
      sync1_r <= irq_pin_n;
      sync2_r <= sync1_r;
      prev_r <= sync2_r;
      port_s1_r <= port_a_line_two_in;
      port_s2_r <= port_s1_r;
    end
  end

  logic fall_edge;
  assign fall_edge = prev_r & ~sync2_r;

  // ---------------------------------------------------------------
  // control registers
  // ---------------------------------------------------------------
  // control bits
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      mask_r <= eipl_pkg::RESET_MASK;
      sense_r <= eipl_pkg::RESET_SENSE;
    end else if (bus.wr && sel_status) begin
      mask_r <= bus.wdata[eipl_pkg::MASK_POS];
      sense_r <= bus.wdata[eipl_pkg::SENSE_POS];
    end
  end

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      pin_en_r <= eipl_pkg::RESET_PIN_ENABLE;
      pullup_dis_r <= eipl_pkg::RESET_PULLUP_DIS;
    end else if (bus.wr && sel_config) begin
      pin_en_r <= bus.wdata[eipl_pkg::PIN_ENABLE_POS];
      pullup_dis_r <= bus.wdata[eipl_pkg::PULLUP_DIS_POS];
    end
  end

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      permit_r <= eipl_pkg::RESET_PERMIT;
    end else if (bus.wr && sel_break) begin
      permit_r <= bus.wdata[eipl_pkg::BREAK_PERMIT_POS];
    end
  end

  // ---------------------------------------------------------------
  // request latch
  // ---------------------------------------------------------------
  logic soft_ack;
  logic ack;
  logic ack_pend_r;
  assign soft_ack = bus.wr && sel_status &&
                    bus.wdata[eipl_pkg::LATCH_CLEAR_POS] &&
                    (!break_active || permit_r);
  assign ack = soft_ack | (vector_fetch & pin_en_r);

  // level mode: remembers an ack taken while pin still low
  // ack and pin high in either order
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      ack_pend_r <= 1'b0;
    end else if (!pin_en_r || fall_edge || !latch_r) begin
      ack_pend_r <= 1'b0;
    end else if (ack && sense_r && !sync2_r) begin
      ack_pend_r <= 1'b1;
    end else if (sync2_r) begin
      ack_pend_r <= 1'b0;
    end
  end

  logic ack_done;
  assign ack_done = ack | ack_pend_r;

  // reset clears latch even if pin held low
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      latch_r <= 1'b0;
    end else if (!pin_en_r) begin
      latch_r <= 1'b0;
    end else if (fall_edge) begin
      latch_r <= 1'b1;
    // edge mode: ack clears at once
    end else if (!sense_r && ack) begin
      latch_r <= 1'b0;
    // level mode: ack plus pin high
    end else if (sense_r && ack_done && sync2_r) begin
      latch_r <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  // mask gates request and wake
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      irq_request <= 1'b0;
      wake_request <= 1'b0;
      pin_level <= 1'b1;
      pin_function_enable <= 1'b0;
      // pull-up is connected out of reset
      pullup_enable <= 1'b1;
    end else begin
      irq_request <= latch_r & ~mask_r;
      wake_request <= latch_r & ~mask_r;
      // disabled pin looks high to branch logic
      pin_level <= pin_en_r ? sync2_r : 1'b1;
      pin_function_enable <= pin_en_r;
      // pull-up unless the disable bit is set
      pullup_enable <= ~pullup_dis_r;
    end
  end

  // unmapped addresses read zero
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      reg_rdata <= 8'h00;
    end else if (!bus.rd) begin
      reg_rdata <= 8'h00;
    end else if (sel_status) begin
      reg_rdata <= {4'h0, latch_r, 1'b0, mask_r, sense_r};
    end else if (sel_config) begin
      reg_rdata <= {6'h00, pin_en_r, pullup_dis_r};
    end else if (sel_break) begin
      reg_rdata <= {permit_r, 7'h00};
    end else if (sel_port) begin
      // line two reads zero while owned
      reg_rdata <= {5'h00, port_s2_r & ~pin_en_r, 2'h0};
    end else begin
      reg_rdata <= 8'h00;
    end
  end

endmodule : eipl_top

// ==== design/eipl_pkg.sv ====
// package: constants and carriers for the external interrupt pin latch
package eipl_pkg;
  // register offsets (byte addresses on the plain register port)
  localparam logic [7:0] STATUS_CONTROL_OFS = 8'h00;
  localparam logic [7:0] CONFIG_TWO_OFS = 8'h01;
  localparam logic [7:0] BREAK_FLAG_OFS = 8'h02;
  localparam logic [7:0] PORT_A_DATA_OFS = 8'h03;
  // status and control field positions
  localparam int PENDING_POS = 3;
  localparam int LATCH_CLEAR_POS = 2;
  localparam int MASK_POS = 1;
  localparam int SENSE_POS = 0;
  // config two field positions
  localparam int PIN_ENABLE_POS = 1;
  localparam int PULLUP_DIS_POS = 0;
  // break flag control field position
  localparam int BREAK_PERMIT_POS = 7;
  // port A line two position
  localparam int PORT_LINE_POS = 2;
  // reset values
  localparam logic RESET_MASK = 1'b0;
  localparam logic RESET_SENSE = 1'b0;
  localparam logic RESET_PIN_ENABLE = 1'b0;
  localparam logic RESET_PULLUP_DIS = 1'b0;
  localparam logic RESET_PERMIT = 1'b0;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } eipl_bus_type;
endpackage : eipl_pkg

// ==== tb/eipl_top_properties.sv ====
// checker: timing relations at the pin latch ports
`timescale 1ns/1ps
module eipl_top_checker (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic irq_pin_n,
  input wire logic vector_fetch,
  input wire logic break_active,
  input wire logic port_a_line_two_in,
  input wire logic irq_request,
  input wire logic wake_request,
  input wire logic pin_level,
  input wire logic pin_function_enable,
  input wire logic pullup_enable
);
  logic mask_r;
  logic sense_r;
  logic permit_r;
  logic sc_wr;
  assign sc_wr = reg_wr && reg_addr == eipl_pkg::STATUS_CONTROL_OFS;
  // shadow copies of the control bits, updated like the design
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      mask_r <= 1'h0;
      sense_r <= 1'h0;
      permit_r <= 1'h0;
    end else begin
      if (sc_wr) begin
        mask_r <= reg_wdata[1];
        sense_r <= reg_wdata[0];
      end
      if (reg_wr && reg_addr == eipl_pkg::BREAK_FLAG_OFS) begin
        permit_r <= reg_wdata[7];
      end
    end
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  wake_follow_a: assert property (wake_request == irq_request)
    else $error("wake output differs from request");
  pin_high_a: assert property (!pin_function_enable &&
    !$past(pin_function_enable) |-> pin_level) else $error("pin level low");
  ack_zero_a: assert property ($past(reg_rd) &&
    $past(reg_addr) == 8'h00 |-> !reg_rdata[2]) else $error("ack bit read 1");
  edge_sets_a: assert property ($fell(irq_pin_n) &&
    pin_function_enable && !mask_r |-> ##[2:5] irq_request)
    else $error("falling edge not latched");
  edge_ack_a: assert property (sc_wr && reg_wdata[2] &&
    !sense_r && !break_active |-> ##2 !irq_request)
    else $error("ack did not clear");
  fetch_clr_a: assert property (vector_fetch &&
    pin_function_enable && !sense_r |-> ##2 !irq_request)
    else $error("fetch did not clear");
  level_hold_a: assert property (!irq_pin_n [*4] ##0
    (sense_r && irq_request && !reg_wr) |=> irq_request)
    else $error("level request dropped");
  break_keep_a: assert property (sc_wr && reg_wdata[2] &&
    !reg_wdata[1] && break_active && !permit_r && irq_request
    |-> ##2 irq_request) else $error("break ack cleared");
  mask_block_a: assert property (mask_r && $past(mask_r)
    |-> !irq_request) else $error("masked request seen");
  cover property (irq_request && sense_r);
  cover property (break_active && permit_r && sc_wr);
  cover property (mask_r && vector_fetch);
endmodule : eipl_top_checker
bind eipl_top eipl_top_checker u_eipl_top_checker (.core_clk, .reset_n,
  .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .irq_pin_n,
  .vector_fetch, .break_active, .port_a_line_two_in, .irq_request,
  .wake_request, .pin_level, .pin_function_enable, .pullup_enable);

// ==== tb/eipl_source.sv ====
// partner: external source pulling the request pin low
`timescale 1ns/1ps
module eipl_source (
  input wire logic core_clk,
  input wire logic go_low,
  output logic irq_pin_n
);
  // drives both levels; irq_pin_n goes back high when go_low drops
  always_ff @(posedge core_clk) begin
    irq_pin_n <= !go_low;
  end
endmodule : eipl_source

// ==== tb/tb.sv ====
// testbench: register and pin scenarios for the pin latch
`timescale 1ns/1ps
module tb;
  logic core_clk, reset_n, reg_wr, reg_rd, vector_fetch, break_active;
  logic port_a_in, go_low, irq_pin_n, irq_request, pin_level;
  logic pin_fn_en, pullup_en;
  logic [7:0] reg_addr, reg_wdata, reg_rdata;
  int miscompares, num_checks;
  eipl_source u_eipl_source (.core_clk, .go_low, .irq_pin_n);
  eipl_top u_eipl_top (.core_clk, .reset_n, .reg_addr, .reg_wdata,
    .reg_wr, .reg_rd, .reg_rdata, .irq_pin_n, .vector_fetch,
    .break_active, .port_a_line_two_in(port_a_in), .irq_request,
    .wake_request(), .pin_level, .pin_function_enable(pin_fn_en),
    .pullup_enable(pullup_en));
  initial begin
    core_clk = 1'h0;
    forever #20 core_clk = ~core_clk;
  end
  task chk(string n, logic [7:0] s, logic [7:0] e);
    num_checks++;
    if (s !== e) begin
      $display("unexpected %s exp %h got %h", n, e, s);
      miscompares++;
    end
  endtask : chk
  task wr(logic [7:0] a, logic [7:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'h1;
    @(posedge core_clk);
    reg_wr <= 1'h0;
  endtask : wr
  task rd(logic [7:0] a, logic [7:0] e);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd <= 1'h1;
    @(posedge core_clk);
    reg_rd <= 1'h0;
    #1 chk("rdata", reg_rdata, e);
  endtask : rd
  // six cycles cover the source flop plus the four-cycle latch path
  task pin(logic low);
    @(posedge core_clk);
    go_low <= low;
    repeat (6) @(posedge core_clk);
  endtask : pin
  task complete_run;
    $display("checks %0d miscompares %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : complete_run
  initial begin
    {reset_n, reg_wr, reg_rd, vector_fetch, break_active, go_low} = 6'h00;
    {port_a_in, reg_addr, reg_wdata, miscompares, num_checks} = 0;
    port_a_in = 1'h1;
    repeat (10) @(posedge core_clk);
    reset_n <= 1'h1;
    rd(8'h00, 8'h00);
    rd(8'h01, 8'h00);
    chk("pullup", {7'h00, pullup_en}, 8'h01);
    chk("pin_fn", {7'h00, pin_fn_en}, 8'h00);
    rd(8'h10, 8'h00);
    pin(1'h1);
    rd(8'h00, 8'h00);
    chk("pin_level", {7'h00, pin_level}, 8'h01);
    $display("reset and disabled pin done");
    pin(1'h0);
    wr(8'h01, 8'h02);
    pin(1'h1);
    chk("pin_fn", {7'h00, pin_fn_en}, 8'h01);
    rd(8'h00, 8'h08);
    rd(8'h03, 8'h00);
    wr(8'h01, 8'h03);
    rd(8'h01, 8'h03);
    chk("pullup", {7'h00, pullup_en}, 8'h00);
    wr(8'h01, 8'h02);
    wr(8'h00, 8'h04);
    rd(8'h00, 8'h00);
    pin(1'h0);
    pin(1'h1);
    rd(8'h00, 8'h08);
    wr(8'h00, 8'h04);
    $display("edge mode done");
    wr(8'h00, 8'h02);
    pin(1'h0);
    pin(1'h1);
    rd(8'h00, 8'h0A);
    chk("irq_request", {7'h00, irq_request}, 8'h00);
    @(posedge core_clk) vector_fetch <= 1'h1;
    @(posedge core_clk) vector_fetch <= 1'h0;
    rd(8'h00, 8'h02);
    $display("mask and fetch done");
    wr(8'h00, 8'h01);
    pin(1'h0);
    pin(1'h1);
    wr(8'h00, 8'h05);
    rd(8'h00, 8'h09);
    pin(1'h0);
    rd(8'h00, 8'h01);
    $display("level mode done");
    @(posedge core_clk) break_active <= 1'h1;
    wr(8'h00, 8'h00);
    pin(1'h1);
    wr(8'h00, 8'h04);
    rd(8'h00, 8'h08);
    wr(8'h02, 8'h80);
    wr(8'h00, 8'h04);
    @(posedge core_clk) break_active <= 1'h0;
    rd(8'h00, 8'h00);
    $display("break done");
    complete_run();
  end
endmodule : tb
